// File: inc/pdm_params.svh
// Purpose: constants of the power-down mode sequencer
// Assumes: included by the package, the assertions and the bench
// Notes: offsets are word indexes on the plain register port
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH

// ***************************************************
// bus and register map
// ***************************************************
`define PDM_ADDR_W 2
`define PDM_DATA_W 8
`define PDM_A_CTRL1 2'h0
`define PDM_A_CTRL2 2'h1
`define PDM_A_MSTBY 2'h2
`define PDM_A_STAT 2'h3
`define PDM_C1_RST 8'h00
`define PDM_C2_RST 8'h00
`define PDM_MSTBY_RST 8'h00

// ***************************************************
// structure and timing
// ***************************************************
`define PDM_NUM_MOD 8
`define PDM_WT_BIT 0
`define PDM_WAIT_BASE 8192
`define PDM_WAIT_W 21
`define PDM_DIV_W 8
`define PDM_PREP_STATES 2'h3

`endif

// File: inc/pdm_pkg.sv
// Purpose: types of the power-down mode sequencer
// Assumes: pdm_params.svh on the include path
// Notes: all block state lives in pdm_st_t
package pdm_pkg;
`include "pdm_params.svh"

	typedef enum logic [2:0] {
		PDM_ACTIVE = 3'b000,
		PDM_SLEEP = 3'b001,
		PDM_SUBACT = 3'b010,
		PDM_SUBSLP = 3'b011,
		PDM_STBY = 3'b100,
		PDM_WAKE = 3'b101,
		PDM_DTPREP = 3'b110,
		PDM_RESET = 3'b111
	} pdm_mode_t;

	typedef struct packed {
		logic standby_sel;
		logic [2:0] standby_wait_sel;
		logic [3:0] rsvd;
	} pdm_ctrl1_t;

	typedef struct packed {
		logic [2:0] active_div;
		logic sleep_mode_select;
		logic direct_transition_flag;
		logic low_speed_on_flag;
		logic [1:0] sub_div;
	} pdm_ctrl2_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [`PDM_ADDR_W-1:0] addr;
		logic [`PDM_DATA_W-1:0] wdata;
	} pdm_bus_t;

	typedef struct packed {
		logic req;
		logic en;
		logic mask;
		logic dt_en;
	} pdm_irq_t;

	typedef struct packed {
		logic sys_osc_en;
		logic cpu_run;
		logic cpu_clk_en;
		logic io_hiz;
		logic io_hold;
		logic periph_rst;
	} pdm_pwr_t;

	typedef struct packed {
		logic int_exc;
		logic dt_exc;
		logic rst_exc;
	} pdm_exc_t;

	typedef struct packed {
		pdm_mode_t mode;
		pdm_ctrl1_t ctrl1;
		pdm_ctrl2_t ctrl2;
		logic [2:0] eff_adiv;
		logic [1:0] eff_sdiv;
		logic [`PDM_NUM_MOD-1:0] mstby;
		logic [`PDM_DIV_W-1:0] div_cnt;
		logic [2:0] sub_cnt;
		logic [`PDM_WAIT_W-1:0] wait_cnt;
		logic [1:0] prep_cnt;
		logic dt_pend;
		logic from_sub;
		logic nowake;
		pdm_pwr_t pwr;
		pdm_exc_t exc;
		logic [`PDM_NUM_MOD-1:0] periph_clk_en;
		logic [`PDM_DATA_W-1:0] rd_data;
	} pdm_st_t;

endpackage : pdm_pkg

// File: hdl/pdm_power_mode_ctrl.sv
// Purpose: power-down mode sequencer with clock dividers and module standby
// Assumes: all inputs synchronous to sys_clk_i; phi_w_tick_i is one pulse per watch clock
// Notes: clock gating is shown as one-cycle enables, not gated clocks
//
// The strobed register port and the register addresses were left to the implementer.
module pdm_power_mode_ctrl
	import pdm_pkg::*;
#(
	parameter int unsigned WAIT_BASE = `PDM_WAIT_BASE
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire pdm_bus_t bus_i,
	input wire pdm_irq_t irq_i,
	input wire logic sleep_exec_i,
	input wire logic ext_reset_n_i,
	input wire logic phi_w_tick_i,
	output logic [`PDM_DATA_W-1:0] rd_data_o,
	output pdm_mode_t mode_o,
	output pdm_pwr_t pwr_o,
	output pdm_exc_t exc_o,
	output logic [`PDM_NUM_MOD-1:0] periph_clk_en_o
);

	// ***************************************************
	// state and helpers
	// ***************************************************
	pdm_st_t st_r;
	pdm_st_t st_nxt;
	logic act_tick;
	logic sub_tick;
	logic old_tick;
	logic wake;
	logic [`PDM_DIV_W-1:0] act_lim;
	logic [2:0] sub_lim;

	// mode chosen by a sleep instruction
	function automatic pdm_mode_t sleep_target(
		input pdm_mode_t cur,
		input pdm_ctrl1_t c1,
		input pdm_ctrl2_t c2,
		input pdm_irq_t irq
	);
		pdm_mode_t t;
		if (c2.direct_transition_flag)
		begin
			if (irq.mask || !irq.dt_en)
				t = (cur == PDM_ACTIVE) ? PDM_SLEEP : PDM_SUBSLP;
			else
				t = PDM_DTPREP;
		end
		else if (c1.standby_sel)
			t = c2.low_speed_on_flag ? PDM_SUBSLP : PDM_STBY;
		else
			t = PDM_SLEEP;
		return t;
	endfunction : sleep_target

	// wait count minus one so the wake state lasts exactly the selected states
	function automatic logic [`PDM_WAIT_W-1:0] wait_load(input logic [2:0] sel);
		return `PDM_WAIT_W'((`PDM_WAIT_W'(WAIT_BASE) << sel) - `PDM_WAIT_W'(1));
	endfunction : wait_load

	// ***************************************************
	// next state
	// ***************************************************
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.exc = '0;
		st_nxt.pwr.cpu_clk_en = 1'b0;
		st_nxt.pwr.periph_rst = 1'b0;
		st_nxt.periph_clk_en = '0;
		st_nxt.rd_data = '0;

		// register port
		if (bus_i.wr)
		begin
			case (bus_i.addr)
				`PDM_A_CTRL1:
				begin
					st_nxt.ctrl1 = pdm_ctrl1_t'(bus_i.wdata);
					st_nxt.ctrl1.rsvd = '0;
				end
				`PDM_A_CTRL2:
					st_nxt.ctrl2 = pdm_ctrl2_t'(bus_i.wdata);
				`PDM_A_MSTBY:
					st_nxt.mstby = bus_i.wdata;
				default:
					st_nxt.mstby = st_r.mstby;
			endcase
		end
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				`PDM_A_CTRL1:
					st_nxt.rd_data = st_r.ctrl1;
				`PDM_A_CTRL2:
					st_nxt.rd_data = st_r.ctrl2;
				`PDM_A_MSTBY:
					st_nxt.rd_data = st_r.mstby;
				default:
					st_nxt.rd_data = `PDM_DATA_W'({st_r.pwr.sys_osc_en, st_r.mode});
			endcase
		end

		// active divider runs on the system clock
		act_lim = `PDM_DIV_W'((`PDM_DIV_W'(1) << st_r.eff_adiv) - `PDM_DIV_W'(1));
		act_tick = (st_r.div_cnt == act_lim);
		st_nxt.div_cnt = act_tick ? '0 : `PDM_DIV_W'(st_r.div_cnt + `PDM_DIV_W'(1));

		// subclock divider: 2, 4 or 8 watch clocks; code 3 wraps to 8
		sub_lim = 3'((3'h2 << st_r.eff_sdiv) - 3'h1);
		sub_tick = phi_w_tick_i && (st_r.sub_cnt == sub_lim);
		if (phi_w_tick_i)
			st_nxt.sub_cnt = sub_tick ? '0 : 3'(st_r.sub_cnt + 3'h1);

		old_tick = st_r.from_sub ? sub_tick : act_tick;
		wake = irq_i.req && irq_i.en && !irq_i.mask && !st_r.nowake;

		case (st_r.mode)
			PDM_ACTIVE, PDM_SUBACT:
			begin
				st_nxt.pwr.cpu_clk_en = (st_r.mode == PDM_ACTIVE) ? act_tick : sub_tick;
				if (sleep_exec_i)
				begin
					st_nxt.eff_adiv = st_r.ctrl2.active_div;
					st_nxt.eff_sdiv = st_r.ctrl2.sub_div;
					st_nxt.mode = sleep_target(st_r.mode, st_r.ctrl1, st_r.ctrl2, irq_i);
					st_nxt.nowake = st_r.ctrl2.direct_transition_flag && irq_i.mask;
					st_nxt.from_sub = (st_r.mode == PDM_SUBACT);
					st_nxt.prep_cnt = '0;
				end
			end
			PDM_SLEEP, PDM_SUBSLP:
			begin
				// no stabilisation wait on this exit
				if (wake)
				begin
					st_nxt.mode = st_r.ctrl2.low_speed_on_flag ? PDM_SUBACT : PDM_ACTIVE;
					st_nxt.exc.int_exc = 1'b1;
				end
			end
			PDM_STBY:
			begin
				if (wake)
				begin
					st_nxt.mode = PDM_WAKE;
					st_nxt.dt_pend = 1'b0;
					st_nxt.wait_cnt = wait_load(st_r.ctrl1.standby_wait_sel);
				end
			end
			PDM_WAKE:
			begin
				if (st_r.wait_cnt == '0)
				begin
					st_nxt.mode = PDM_ACTIVE;
					st_nxt.exc.int_exc = !st_r.dt_pend;
					st_nxt.exc.dt_exc = st_r.dt_pend;
				end
				else
					st_nxt.wait_cnt = `PDM_WAIT_W'(st_r.wait_cnt - `PDM_WAIT_W'(1));
			end
			PDM_DTPREP:
			begin
				// sleep and internal states still run on the old clock
				st_nxt.pwr.cpu_clk_en = old_tick;
				if (old_tick)
				begin
					if (st_r.prep_cnt == `PDM_PREP_STATES - 2'h1)
					begin
						if (st_r.from_sub)
						begin
							st_nxt.mode = PDM_WAKE;
							st_nxt.dt_pend = 1'b1;
							st_nxt.wait_cnt = wait_load(st_r.ctrl1.standby_wait_sel);
						end
						else
						begin
							st_nxt.mode = PDM_SUBACT;
							st_nxt.exc.dt_exc = 1'b1;
						end
					end
					else
						st_nxt.prep_cnt = 2'(st_r.prep_cnt + 2'h1);
				end
			end
			PDM_RESET:
			begin
				if (ext_reset_n_i)
				begin
					st_nxt.mode = PDM_ACTIVE;
					st_nxt.exc.rst_exc = 1'b1;
				end
			end
			default:
				st_nxt.mode = PDM_ACTIVE;
		endcase

		// pin low wins over every other transition
		if (!ext_reset_n_i)
		begin
			st_nxt.mode = PDM_RESET;
			st_nxt.nowake = 1'b0;
			st_nxt.exc = '0;
		end

		// sleep select resets the timer, serial and converter on any change
		if (st_nxt.mode != st_r.mode)
			st_nxt.pwr.periph_rst = st_r.ctrl2.sleep_mode_select;

		// ***************************************************
		// power controls from the coming mode
		// ***************************************************
		case (st_nxt.mode)
			PDM_ACTIVE, PDM_SLEEP, PDM_WAKE, PDM_RESET:
				st_nxt.pwr.sys_osc_en = 1'b1;
			PDM_DTPREP:
				st_nxt.pwr.sys_osc_en = !st_nxt.from_sub;
			default:
				st_nxt.pwr.sys_osc_en = 1'b0;
		endcase
		st_nxt.pwr.cpu_run = (st_nxt.mode == PDM_ACTIVE) || (st_nxt.mode == PDM_SUBACT)
			|| (st_nxt.mode == PDM_DTPREP);
		st_nxt.pwr.io_hiz = (st_nxt.mode == PDM_STBY);
		st_nxt.pwr.io_hold = (st_nxt.mode == PDM_SUBSLP);

		// per-module clock enables; standby and wake give none
		for (int i = 0; i < `PDM_NUM_MOD; i++)
		begin
			case (st_r.mode)
				PDM_ACTIVE, PDM_SLEEP:
					st_nxt.periph_clk_en[i] = act_tick && !st_r.mstby[i];
				PDM_SUBACT:
					st_nxt.periph_clk_en[i] = sub_tick && !st_r.mstby[i];
				PDM_SUBSLP:
					st_nxt.periph_clk_en[i] = (i == `PDM_WT_BIT) && sub_tick && !st_r.mstby[i];
				PDM_DTPREP:
					st_nxt.periph_clk_en[i] = old_tick && !st_r.mstby[i];
				default:
					st_nxt.periph_clk_en[i] = 1'b0;
			endcase
			// last tick of the old mode must not leak into a halted one
			if ((st_nxt.mode == PDM_SUBSLP) && (i != `PDM_WT_BIT))
				st_nxt.periph_clk_en[i] = 1'b0;
			if ((st_nxt.mode == PDM_STBY) || (st_nxt.mode == PDM_WAKE) || (st_nxt.mode == PDM_RESET))
				st_nxt.periph_clk_en[i] = 1'b0;
		end
	end

	// ***************************************************
	// registers
	// ***************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
			st_r.ctrl1 <= pdm_ctrl1_t'(`PDM_C1_RST);
			st_r.ctrl2 <= pdm_ctrl2_t'(`PDM_C2_RST);
			st_r.mstby <= `PDM_MSTBY_RST;
			st_r.mode <= PDM_ACTIVE;
			st_r.pwr.sys_osc_en <= 1'b1;
			st_r.pwr.cpu_run <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign rd_data_o = st_r.rd_data;
	assign mode_o = st_r.mode;
	assign pwr_o = st_r.pwr;
	assign exc_o = st_r.exc;
	assign periph_clk_en_o = st_r.periph_clk_en;

endmodule : pdm_power_mode_ctrl

// File: testbench/pdm_power_mode_ctrl_asserts.sv
// Purpose: port checks of the mode sequencer
// Assumes: WAIT_BASE of 4 or more
// Notes: no register view here
`include "pdm_params.svh"
module pdm_power_mode_ctrl_asserts
	import pdm_pkg::*;
#(
	parameter int unsigned WAIT_BASE = 4
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire pdm_irq_t irq_i,
	input wire logic ext_reset_n_i,
	input wire pdm_mode_t mode_o,
	input wire pdm_pwr_t pwr_o,
	input wire pdm_exc_t exc_o,
	input wire logic [`PDM_NUM_MOD-1:0] periph_clk_en_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	AST_STBY: assert property (mode_o == PDM_STBY |-> !pwr_o.sys_osc_en && pwr_o.io_hiz)
		else $error("standby outputs wrong");
	AST_STBY_EXIT: assert property ($past(mode_o) == PDM_STBY && mode_o != PDM_STBY
		|-> (mode_o == PDM_WAKE && pwr_o.sys_osc_en) || mode_o == PDM_RESET) else $error("standby exit skips wait");
	AST_NO_WAKE: assert property (mode_o inside {PDM_STBY, PDM_SUBSLP} && (irq_i.mask || !irq_i.en)
		&& ext_reset_n_i |=> $stable(mode_o)) else $error("blocked interrupt woke");
	AST_PIN: assert property (!ext_reset_n_i |=> mode_o == PDM_RESET && pwr_o.sys_osc_en && !pwr_o.cpu_run)
		else $error("pin reset ignored");
	AST_SUBSLP: assert property (mode_o == PDM_SUBSLP |-> pwr_o.io_hold && !pwr_o.cpu_run
		&& periph_clk_en_o[7:1] == 7'h00) else $error("subsleep not halted");
	AST_SUB_EXIT: assert property ($past(mode_o) == PDM_SUBSLP && !(mode_o inside {PDM_SUBSLP, PDM_RESET})
		|-> exc_o.int_exc && mode_o inside {PDM_ACTIVE, PDM_SUBACT}) else $error("subsleep exit wrong");
	AST_WAIT: assert property ($rose(mode_o == PDM_WAKE) |-> (mode_o inside {PDM_WAKE, PDM_RESET})[*4])
		else $error("wait cut short");
	AST_DT: assert property ($past(mode_o) == PDM_DTPREP && mode_o == PDM_SUBACT |-> exc_o.dt_exc)
		else $error("direct exception missing");
	AST_SLEEP: assert property (mode_o == PDM_SLEEP |-> !pwr_o.cpu_run && pwr_o.sys_osc_en)
		else $error("sleep outputs wrong");
endmodule : pdm_power_mode_ctrl_asserts
bind pdm_power_mode_ctrl pdm_power_mode_ctrl_asserts #(.WAIT_BASE(WAIT_BASE)) i_chk (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .irq_i(irq_i), .ext_reset_n_i(ext_reset_n_i), .mode_o(mode_o), .pwr_o(pwr_o),
	.exc_o(exc_o), .periph_clk_en_o(periph_clk_en_o));

// File: testbench/pdm_far_model.sv
// Purpose: watch ticks and reset pin of the far side
// Assumes: one clock
// Notes: fast ticks keep subactive runs short
module pdm_far_model
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic pin_go_i,
	output logic phi_w_tick_o,
	output logic ext_reset_n_o
);
	logic [2:0] tick_r;
	logic [4:0] hold_r;
	always_ff @(posedge sys_clk_i)
	begin
		tick_r <= (rst_i || tick_r == 3'h4) ? 3'h0 : tick_r + 3'h1;
		hold_r <= rst_i ? 5'h00 : pin_go_i ? 5'h1f : hold_r - {4'h0, hold_r != 5'h00};
	end
	assign phi_w_tick_o = tick_r == 3'h4;
	// held low long past oscillator start
	assign ext_reset_n_o = hold_r == 5'h00;
endmodule : pdm_far_model

// File: testbench/pdm_power_mode_ctrl_bench.sv
// Purpose: self-checking bench of the mode sequencer
// Assumes: WAIT_BASE of 4, tick every 5 cycles
// Notes: fixed seed, so runs repeat
`include "pdm_params.svh"
module pdm_power_mode_ctrl_bench
	import pdm_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	pdm_bus_t bus = '0;
	pdm_irq_t irq = '0;
	logic slp = 1'b0;
	logic pin_go = 1'b0;
	logic tick;
	logic pin_n;
	logic [7:0] rdat;
	pdm_mode_t mode;
	pdm_pwr_t pwr;
	pdm_exc_t exc;
	logic [7:0] pclk;
	int fails = 0, checks_done = 0, ncpu, nper, nprst, ndt, nrst, k;
	integer seed = 32'h8abc320b;
	logic [2:0] sel;
	logic [7:0] d;
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		ncpu += pwr.cpu_clk_en;
		nper += pclk[1];
		nprst += pwr.periph_rst;
		ndt += exc.dt_exc;
		nrst += exc.rst_exc;
	end
	pdm_power_mode_ctrl #(.WAIT_BASE(4)) i_pdm_power_mode_ctrl (.sys_clk_i(sys_clk), .rst_i(rst), .bus_i(bus),
		.irq_i(irq), .sleep_exec_i(slp), .ext_reset_n_i(pin_n), .phi_w_tick_i(tick), .rd_data_o(rdat),
		.mode_o(mode), .pwr_o(pwr), .exc_o(exc), .periph_clk_en_o(pclk));
	pdm_far_model i_pdm_far_model (.sys_clk_i(sys_clk), .rst_i(rst), .pin_go_i(pin_go), .phi_w_tick_o(tick),
		.ext_reset_n_o(pin_n));
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task tk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tk
	task win(input int n);
		tk(4);
		ncpu = 0;
		nper = 0;
		nprst = 0;
		ndt = 0;
		tk(n);
	endtask : win
	task wr(input logic [1:0] a, input logic [7:0] v);
		bus <= '{1'b1, 1'b0, a, v};
		tk(1);
		bus <= '0;
	endtask : wr
	task rc(input logic [1:0] a, input logic [7:0] e);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		tk(1);
		bus <= '0;
		chk(16'(rdat), 16'(e));
	endtask : rc
	task go_sleep;
		slp <= 1'b1;
		tk(1);
		slp <= 1'b0;
	endtask : go_sleep
	task wm(input pdm_mode_t m);
		k = 0;
		while (mode !== m && k < 2000)
		begin
			tk(1);
			k++;
		end
		chk(16'(mode), 16'(m));
	endtask : wm
	// generous: real run is under 2000 cycles, limit is 10000
	initial
	begin
		#40000;
		fails++;
		close_out();
	end
	// ********
	// main sequence
	// ********
	initial
	begin
		irq <= 4'h1;
		tk(8);
		rst <= 1'b0;
		tk(1);
		rc(2'h0, 8'h00);
		rc(2'h1, 8'h00);
		rc(2'h2, 8'h00);
		wr(2'h3, 8'hff);
		wr(2'h0, 8'hff);
		rc(2'h0, 8'hf0);
		rc(2'h3, 8'h08);
		wr(2'h0, 8'h00);
		wr(2'h1, 8'h50);
		win(8);
		chk(16'(ncpu), 16'd8);
		go_sleep();
		wm(PDM_SLEEP);
		irq <= 4'hd;
		wm(PDM_ACTIVE);
		irq <= 4'h1;
		tk(1);
		chk(16'(nprst), 16'd2);
		win(16);
		chk(16'(ncpu), 16'd4);
		wr(2'h2, 8'hff);
		win(16);
		chk(16'(nper), 16'd0);
		wr(2'h2, 8'h00);
		win(16);
		chk(16'(nper), 16'd4);
		$display("test active done");
		wr(2'h1, 8'h00);
		repeat (2)
		begin
			sel = 3'($random(seed));
			wr(2'h0, {1'b1, sel, 4'h0});
			go_sleep();
			wm(PDM_STBY);
			repeat (4)
			begin
				d = 8'($random(seed));
				irq <= {1'b1, d[0], d[1] | d[0], 1'b1};
				tk(1);
			end
			chk(16'(mode), 16'(PDM_STBY));
			irq <= 4'hd;
			wm(PDM_WAKE);
			irq <= 4'h1;
			wm(PDM_ACTIVE);
			chk(16'(k), 16'(4 << sel));
		end
		$display("test standby done");
		wr(2'h1, 8'h07);
		go_sleep();
		wm(PDM_SUBSLP);
		irq <= 4'hd;
		wm(PDM_SUBACT);
		irq <= 4'h1;
		chk(16'(k), 16'd1);
		win(80);
		chk(16'(ncpu), 16'd2);
		wr(2'h1, 8'h0f);
		go_sleep();
		wm(PDM_DTPREP);
		wm(PDM_WAKE);
		wm(PDM_ACTIVE);
		chk(16'(k), 16'(4 << sel));
		tk(1);
		chk(16'(ndt), 16'd1);
		go_sleep();
		wm(PDM_DTPREP);
		wm(PDM_SUBACT);
		tk(1);
		chk(16'(ndt), 16'd2);
		$display("test direct done");
		irq <= 4'h0;
		go_sleep();
		wm(PDM_SUBSLP);
		irq <= 4'hc;
		wm(PDM_SUBACT);
		irq <= 4'h3;
		go_sleep();
		wm(PDM_SUBSLP);
		irq <= 4'hd;
		tk(8);
		chk(16'(mode), 16'(PDM_SUBSLP));
		irq <= 4'h1;
		pin_go <= 1'b1;
		tk(1);
		pin_go <= 1'b0;
		wm(PDM_RESET);
		wm(PDM_ACTIVE);
		tk(1);
		chk(16'(nrst), 16'd1);
		$display("test pin reset done");
		close_out();
	end
endmodule : pdm_power_mode_ctrl_bench
